// File: src/port_mux_pkg.sv
// Package for the port and pin-function block: register map, field positions, modes, carriers.
// Assumes a 32-bit APB with one register per aligned word.
`default_nettype none
package port_mux_pkg;
    // Register indexes (byte address is four times the index)
    localparam logic [7:0] IDX_P0_LATCH   = 8'h80;
    localparam logic [7:0] IDX_P0_MODE_A  = 8'h84;
    localparam logic [7:0] IDX_P0_MODE_B  = 8'h85;
    localparam logic [7:0] IDX_P1_LATCH   = 8'h90;
    localparam logic [7:0] IDX_P1_MODE_A  = 8'h91;
    localparam logic [7:0] IDX_P1_MODE_B  = 8'h92;
    localparam logic [7:0] IDX_P2_LATCH   = 8'ha0;
    localparam logic [7:0] IDX_P2_MODE_A  = 8'ha4;
    localparam logic [7:0] IDX_P2_MODE_B  = 8'ha5;
    localparam logic [7:0] IDX_P0_IN_DIS  = 8'hf6;
    localparam logic [7:0] IDX_PIN_STATUS = 8'hf0;
    localparam logic [7:0] MODE_RESET     = 8'h00;
    localparam logic [7:0] IN_DIS_RESET   = 8'h00;
    // Fields of port two mode register a
    localparam int BIT_P2_SCHMITT   = 7;
    localparam int BIT_P1_SCHMITT   = 6;
    localparam int BIT_P0_SCHMITT   = 5;
    localparam int BIT_CLK_OUT_EN   = 4;
    localparam int BIT_T1_TOGGLE_EN = 3;
    localparam int BIT_T0_TOGGLE_EN = 2;
    // Port one pins with fixed functions; T1 sits on port zero
    localparam int PIN_TXD   = 0;
    localparam int PIN_RXD   = 1;
    localparam int PIN_T0    = 2;
    localparam int PIN_EXTERNAL_IRQ_ZERO_PIN  = 3;
    localparam int PIN_EXTERNAL_IRQ_ONE_PIN  = 4;
    localparam int PIN_RESET = 5;
    localparam int PIN_T1    = 7;
    // Port one mode bits that are writable (5, 3 and 2 are fixed)
    localparam logic [7:0] P1_MODE_WMASK = 8'hd3;
    localparam logic [7:0] P2_LATCH_WMASK = 8'h03;
    localparam logic [7:0] P2_MODE_B_WMASK = 8'h03;
    localparam logic [2:0] CLK_DIV_LAST = 3'h5;

    typedef enum logic [1:0] {
        MODE_QUASI  = 2'b00,
        MODE_PUSH   = 2'b01,
        MODE_INPUT  = 2'b10,
        MODE_OPEN   = 2'b11
    } pin_mode_e;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] mode_a;
        logic [7:0] mode_b;
    } port_regs_s;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } pin_drive_s;

    typedef struct packed {
        logic       reset_pin_en;
        logic       crystal_en;
        logic       reset_level_high;
    } user_config_s;
endpackage
`default_nettype wire

// File: src/port_pin_driver.sv
// One 8-bit port's pin drivers: decodes each pin's mode pair and drives output and enable.
// Assumes pin inputs synchronous to the clock and alternate data already merged by the caller.
`default_nettype none
module port_pin_driver
    import port_mux_pkg::*;
(
    input  wire logic [7:0] mode_a_i,
    input  wire logic [7:0] mode_b_i,
    input  wire logic [7:0] data_i,
    input  wire logic [7:0] force_open_i,
    input  wire logic [7:0] pin_in_q_i,
    output pin_drive_s      drive_o
);
    always_comb begin
        drive_o = '0;
        for (int i = 0; i < 8; i++) begin
            // Each pin decodes only its own pair
            unique case (pin_mode_e'({mode_a_i[i], mode_b_i[i]})) // RQ2 RQ14 RQ18
                MODE_QUASI: begin
                    // Strong low for a zero; strong high after a rise until the registered pin reads high, then released
                    drive_o.o[i]  = data_i[i];
                    drive_o.oe[i] = ~data_i[i] | (data_i[i] & ~pin_in_q_i[i]);
                end
                MODE_PUSH: begin
                    drive_o.o[i]  = data_i[i];
                    drive_o.oe[i] = 1'b1;
                end
                MODE_INPUT: begin
                    drive_o.o[i]  = 1'b0;
                    drive_o.oe[i] = 1'b0;
                end
                MODE_OPEN: begin
                    drive_o.o[i]  = 1'b0;
                    drive_o.oe[i] = ~data_i[i];
                end
            endcase
            if (force_open_i[i]) begin
                drive_o.o[i]  = 1'b0;
                drive_o.oe[i] = ~data_i[i] & ~(mode_a_i[i] & ~mode_b_i[i]); // RQ6
            end
        end
    end
endmodule
`default_nettype wire

// File: src/port_pin_function_mux.sv
// Port latches, modes and alternate-function routing for three ports behind an APB slave.
// Assumes one 40 MHz clock; peripherals and the CPU sit outside and use the ports below.
//
// The implementer's own choice: register access over APB.
`default_nettype none
// Notes on behaviour
// RQ1 - Reset puts latches quasi-bidirectional, all ones or zeros by reset-level bit.
// RQ2 - Each pin's output type is configured independently; the code keeps port one pins 2, 3 and 5 at their reset mode bits.
// RQ3 - With reset pin selected, low level resets chip; CPU restarts at 0.
// RQ4 - Reset pin is external reset only when configuration selects it.
// RQ5 - Otherwise reset pin is a Schmitt input with no driver.
// RQ6 - Two-wire bus pins drive open-drain only.
// RQ7 - Clock-output pin gives CPU clock divided by 6 when enabled, RC/external.
// RQ8 - Crystal option turns oscillator pins into amplifier output and input.
// RQ9 - Each timer may toggle its pin on overflow; else pin is count input.
// RQ10 - Serial transmit on port one pin 0, receive from pin 1.
// RQ11 - External interrupts come from port one pins 3 and 4.
// RQ12 - Eight keypad interrupt inputs on port zero.
// RQ13 - Port two has only two I/O bits with configurable output type.
// RQ14 - Four modes: quasi-bidirectional, open-drain, push-pull, input-only.
// RQ15 - Per-port Schmitt select bits live in port two mode register a.
// RQ16 - Input-disable bit turns off port zero digital input; reads give 0.
// RQ17 - Software puts analog pins in input-only mode.
// RQ18 - Mode from bit pair of two mode registers; both zero is quasi.
// RQ19 - Alternate outputs reach a pin only when enabled; else latch drives.
module port_pin_function_mux
    import port_mux_pkg::*;
(
    input  wire logic                       CLK_I,
    input  wire logic                       RST_I,
    input  wire logic                       PSEL_I,
    input  wire logic                       PENABLE_I,
    input  wire logic                       PWRITE_I,
    input  wire logic [11:0]                PADDR_I,
    input  wire logic [31:0]                PWDATA_I,
    output logic      [31:0]                PRDATA_O,
    output logic                            PREADY_O,
    output logic                            PSLVERR_O,
    input  wire port_mux_pkg::user_config_s CONFIG_I,
    input  wire logic [7:0]                 P0_IN_I,
    output logic      [7:0]                 P0_OUT_O,
    output logic      [7:0]                 P0_OE_O,
    input  wire logic [7:0]                 P1_IN_I,
    output logic      [7:0]                 P1_OUT_O,
    output logic      [7:0]                 P1_OE_O,
    input  wire logic [1:0]                 P2_IN_I,
    output logic      [1:0]                 P2_OUT_O,
    output logic      [1:0]                 P2_OE_O,
    output logic      [7:0]                 SCHMITT_EN_O,
    output logic      [7:0]                 P0_IN_ENABLE_O,
    input  wire logic                       SERIAL_TX_I,
    input  wire logic                       SERIAL_TX_EN_I,
    output logic                            SERIAL_RX_O,
    input  wire logic                       TWI_EN_I,
    input  wire logic                       TWI_SCL_I,
    input  wire logic                       TWI_SDA_I,
    output logic                            TWI_SCL_O,
    output logic                            TWI_SDA_O,
    input  wire logic                       TIMER_ZERO_OVF_I,
    input  wire logic                       TIMER_ONE_OVF_I,
    output logic                            TIMER_ZERO_PIN_O,
    output logic                            TIMER_ONE_PIN_O,
    output logic                            EXTERNAL_IRQ_ZERO_PIN_O,
    output logic                            EXTERNAL_IRQ_ONE_PIN_O,
    output logic      [7:0]                 KEYPAD_IN_O,
    output logic                            OSC_AMP_OUT_SEL_O,
    output logic                            OSC_INPUT_PIN_O,
    output logic                            CHIP_RESET_O,
    output logic      [31:0]                RESTART_ADDR_O
);
    import port_mux_pkg::*;

    typedef struct packed {
        port_regs_s p0;
        port_regs_s p1;
        port_regs_s p2;
        logic [7:0] in_dis;
        logic [2:0] div_cnt;
        logic       clk_out;
        logic       t0_pin;
        logic       t1_pin;
        logic [7:0] p0_in;
        logic [7:0] p1_in;
        logic [1:0] p2_in;
        logic       pin_reset;
        logic       level_loaded;
        logic [31:0] rdata;
    } state_s;

    state_s state_q;
    state_s state_d;

    logic [7:0]  idx;
    logic        access;
    logic        wr;
    logic        hit;
    logic [7:0]  wdat;
    logic [7:0]  p0_data;
    logic [7:0]  p1_data;
    logic [7:0]  p2_data;
    logic [7:0]  p1_open;
    logic [7:0]  p2_mode_a;
    logic [7:0]  p2_mode_b;
    logic [7:0]  p0_mode_a;
    logic [7:0]  p0_mode_b;
    logic [7:0]  p1_mode_a;
    logic [7:0]  p1_mode_b;
    logic [7:0]  p2_in_q_w;
    logic        osc_ext_clock;
    pin_drive_s  p0_drv;
    pin_drive_s  p1_drv;
    pin_drive_s  p2_drv;

    // Register value as software reads it; latch indexes return registered pins, disabled port zero inputs forced low
    function automatic logic [7:0] read_reg(input state_s s, input logic [7:0] index);
        logic [7:0] v;
        v = 8'h00;
        unique case (index)
            IDX_P0_LATCH:   v = s.p0_in & ~s.in_dis; // RQ16
            IDX_P0_MODE_A:  v = s.p0.mode_a;
            IDX_P0_MODE_B:  v = s.p0.mode_b;
            IDX_P1_LATCH:   v = s.p1_in;
            IDX_P1_MODE_A:  v = s.p1.mode_a;
            IDX_P1_MODE_B:  v = s.p1.mode_b;
            IDX_P2_LATCH:   v = {6'h00, s.p2_in};
            IDX_P2_MODE_A:  v = s.p2.mode_a;
            IDX_P2_MODE_B:  v = s.p2.mode_b;
            IDX_P0_IN_DIS:  v = s.in_dis;
            IDX_PIN_STATUS: v = {4'h0, s.clk_out, s.t1_pin, s.t0_pin, s.pin_reset};
            default:        v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic reg_known(input logic [7:0] index);
        return index inside {IDX_P0_LATCH, IDX_P0_MODE_A, IDX_P0_MODE_B, IDX_P1_LATCH,
                             IDX_P1_MODE_A, IDX_P1_MODE_B, IDX_P2_LATCH, IDX_P2_MODE_A,
                             IDX_P2_MODE_B, IDX_P0_IN_DIS, IDX_PIN_STATUS};
    endfunction

    assign idx    = PADDR_I[9:2];
    assign access = PSEL_I & PENABLE_I;
    assign hit    = reg_known(idx) && (PADDR_I[1:0] == 2'b00) && (PADDR_I[11:10] == 2'b00);
    assign wr     = access & PWRITE_I & hit;
    assign wdat   = PWDATA_I[7:0];
    assign osc_ext_clock = ~CONFIG_I.crystal_en;

    always_comb begin
        state_d = state_q;
        state_d.p0_in = P0_IN_I;
        state_d.p1_in = P1_IN_I;
        state_d.p2_in = P2_IN_I;
        // External reset request only when the pin is configured for it
        state_d.pin_reset = CONFIG_I.reset_pin_en & ~P1_IN_I[PIN_RESET]; // RQ3 RQ4
        // Reset level from the user configuration is loaded once after release
        if (!state_q.level_loaded) begin
            state_d.level_loaded = 1'b1;
            state_d.p0.latch = {8{CONFIG_I.reset_level_high}}; // RQ1
            state_d.p1.latch = {8{CONFIG_I.reset_level_high}}; // RQ1
            state_d.p2.latch = {6'h00, {2{CONFIG_I.reset_level_high}}}; // RQ1 RQ13
        end
        // Divide-by-6 clock out: one toggle every three cycles
        if (state_q.p2.mode_a[BIT_CLK_OUT_EN] && osc_ext_clock) begin // RQ7
            if (state_q.div_cnt == 3'h2 || state_q.div_cnt == CLK_DIV_LAST) begin
                state_d.clk_out = ~state_q.clk_out;
            end
            state_d.div_cnt = (state_q.div_cnt == CLK_DIV_LAST) ? 3'h0 : state_q.div_cnt + 3'h1;
        end else begin
            state_d.div_cnt = 3'h0;
            state_d.clk_out = 1'b0;
        end
        // Timer pins toggle on overflow when enabled
        if (TIMER_ZERO_OVF_I && state_q.p2.mode_a[BIT_T0_TOGGLE_EN]) begin // RQ9
            state_d.t0_pin = ~state_q.t0_pin;
        end
        if (TIMER_ONE_OVF_I && state_q.p2.mode_a[BIT_T1_TOGGLE_EN]) begin // RQ9
            state_d.t1_pin = ~state_q.t1_pin;
        end
        if (wr) begin
            unique case (idx)
                IDX_P0_LATCH:  state_d.p0.latch  = wdat;
                IDX_P0_MODE_A: state_d.p0.mode_a = wdat;
                IDX_P0_MODE_B: state_d.p0.mode_b = wdat;
                IDX_P1_LATCH:  state_d.p1.latch  = wdat;
                IDX_P1_MODE_A: state_d.p1.mode_a = wdat & P1_MODE_WMASK;
                IDX_P1_MODE_B: state_d.p1.mode_b = wdat & P1_MODE_WMASK;
                IDX_P2_LATCH:  state_d.p2.latch  = wdat & P2_LATCH_WMASK; // RQ13
                IDX_P2_MODE_A: state_d.p2.mode_a = wdat; // RQ15
                IDX_P2_MODE_B: state_d.p2.mode_b = wdat & P2_MODE_B_WMASK;
                IDX_P0_IN_DIS: state_d.in_dis    = wdat; // RQ16
                default: begin
                end
            endcase
        end
        state_d.rdata = {24'h000000, read_reg(state_q, idx)};
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q <= '0; // RQ1
        end else begin
            state_q <= state_d;
        end
    end

    // Alternate data on each pin; latch value when the function is off
    always_comb begin
        p0_data = state_q.p0.latch;
        if (state_q.p2.mode_a[BIT_T1_TOGGLE_EN]) begin // RQ19
            p0_data[PIN_T1] = state_q.t1_pin;
        end
        p1_data = state_q.p1.latch;
        if (SERIAL_TX_EN_I) begin // RQ10 RQ19
            p1_data[PIN_TXD] = state_q.p1.latch[PIN_TXD] & SERIAL_TX_I;
        end
        if (state_q.p2.mode_a[BIT_T0_TOGGLE_EN]) begin // RQ9 RQ19
            p1_data[PIN_T0] = state_q.t0_pin;
        end
        if (TWI_EN_I) begin
            p1_data[PIN_T0]   = state_q.p1.latch[PIN_T0] & TWI_SCL_I;
            p1_data[PIN_EXTERNAL_IRQ_ZERO_PIN] = state_q.p1.latch[PIN_EXTERNAL_IRQ_ZERO_PIN] & TWI_SDA_I;
        end
        p2_data = {6'h00, state_q.p2.latch[1:0]};
        // Reset level reaches the pins while reset is held, not a cycle late
        if (!state_q.level_loaded) begin // RQ1
            p0_data = {8{CONFIG_I.reset_level_high}};
            p1_data = {8{CONFIG_I.reset_level_high}};
            p2_data = {6'h00, {2{CONFIG_I.reset_level_high}}};
        end
        if (state_q.p2.mode_a[BIT_CLK_OUT_EN] && osc_ext_clock) begin // RQ7 RQ19
            p2_data[0] = state_q.clk_out;
        end
        p1_open = TWI_EN_I ? 8'h0c : 8'h00; // RQ6
    end

    assign p0_mode_a = state_q.p0.mode_a;
    assign p0_mode_b = state_q.p0.mode_b;
    assign p1_mode_a = state_q.p1.mode_a;
    assign p1_mode_b = state_q.p1.mode_b;
    assign p2_mode_a = {6'h00, state_q.p2.mode_a[1:0]};
    assign p2_mode_b = {6'h00, state_q.p2.mode_b[1:0]};
    assign p2_in_q_w = {6'h00, state_q.p2_in};

    port_pin_driver u_p0 (
        .mode_a_i     (p0_mode_a),
        .mode_b_i     (p0_mode_b),
        .data_i       (p0_data),
        .force_open_i (8'h00),
        .pin_in_q_i   (state_q.p0_in),
        .drive_o      (p0_drv)
    );

    port_pin_driver u_p1 (
        .mode_a_i     (p1_mode_a),
        .mode_b_i     (p1_mode_b),
        .data_i       (p1_data),
        .force_open_i (p1_open),
        .pin_in_q_i   (state_q.p1_in),
        .drive_o      (p1_drv)
    );

    port_pin_driver u_p2 (
        .mode_a_i     (p2_mode_a),
        .mode_b_i     (p2_mode_b),
        .data_i       (p2_data),
        .force_open_i (8'h00),
        .pin_in_q_i   (p2_in_q_w),
        .drive_o      (p2_drv)
    );

    assign P0_OUT_O = p0_drv.o;
    assign P0_OE_O  = p0_drv.oe;
    // Reset pin never drives, whatever its mode bits say
    assign P1_OUT_O = p1_drv.o & ~(8'h01 << PIN_RESET); // RQ5
    assign P1_OE_O  = p1_drv.oe & ~(8'h01 << PIN_RESET); // RQ5
    // Crystal option hands both oscillator pins to the amplifier
    assign P2_OUT_O = CONFIG_I.crystal_en ? 2'b00 : p2_drv.o[1:0]; // RQ8
    assign P2_OE_O  = CONFIG_I.crystal_en ? 2'b00 : p2_drv.oe[1:0]; // RQ8
    assign OSC_AMP_OUT_SEL_O = CONFIG_I.crystal_en; // RQ8
    assign OSC_INPUT_PIN_O   = CONFIG_I.crystal_en & P2_IN_I[1]; // RQ8

    // Schmitt thresholds: one select bit per port, port one also forced Schmitt while the reset pin is not selected
    assign SCHMITT_EN_O = {5'h00, state_q.p2.mode_a[BIT_P2_SCHMITT],
                           state_q.p2.mode_a[BIT_P1_SCHMITT] | ~CONFIG_I.reset_pin_en,
                           state_q.p2.mode_a[BIT_P0_SCHMITT]}; // RQ15 RQ5
    assign P0_IN_ENABLE_O = ~state_q.in_dis; // RQ16

    assign SERIAL_RX_O             = state_q.p1_in[PIN_RXD]; // RQ10
    assign TWI_SCL_O               = state_q.p1_in[PIN_T0];
    assign TWI_SDA_O               = state_q.p1_in[PIN_EXTERNAL_IRQ_ZERO_PIN];
    assign TIMER_ZERO_PIN_O        = state_q.p1_in[PIN_T0]; // RQ9
    assign TIMER_ONE_PIN_O         = state_q.p0_in[PIN_T1]; // RQ9
    assign EXTERNAL_IRQ_ZERO_PIN_O = state_q.p1_in[PIN_EXTERNAL_IRQ_ZERO_PIN]; // RQ11
    assign EXTERNAL_IRQ_ONE_PIN_O  = state_q.p1_in[PIN_EXTERNAL_IRQ_ONE_PIN]; // RQ11
    assign KEYPAD_IN_O             = state_q.p0_in & ~state_q.in_dis; // RQ12
    assign CHIP_RESET_O            = state_q.pin_reset; // RQ3
    assign RESTART_ADDR_O          = 32'h00000000; // RQ3

    assign PRDATA_O  = state_d.rdata;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = access & ~hit;
endmodule
`default_nettype wire

// File: tb/port_board_model.sv
// Board model: resolves each port pin from the block's drive and the board drivers.
// Assumes pins packed as port two, one, zero; every pin has a weak pull-up.
`default_nettype none
module port_board_model (
    input  wire logic [17:0] out_i,
    input  wire logic [17:0] oe_i,
    input  wire logic [17:0] ext_en_i,
    input  wire logic [17:0] ext_i,
    output logic      [17:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wired-AND: a low from either side wins, released pins go to the pull-up
    always_comb begin
        for (int i = 0; i < 18; i++) begin
            pin_o[i] = (oe_i[i] ? out_i[i] : 1'b1) & (ext_en_i[i] ? ext_i[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// File: tb/port_pin_function_mux_asserts.sv
// Checker for pin routing relations at the ports of port_pin_function_mux.
// Assumes one clock and an asynchronous active-high reset; bound below.
`default_nettype none
module port_pin_function_mux_asserts (
    input wire logic                       CLK_I,
    input wire logic                       RST_I,
    input wire port_mux_pkg::user_config_s CONFIG_I,
    input wire logic [7:0]                 P0_IN_I,
    input wire logic [7:0]                 P1_IN_I,
    input wire logic [1:0]                 P2_IN_I,
    input wire logic [7:0]                 P1_OUT_O,
    input wire logic [7:0]                 P1_OE_O,
    input wire logic [7:0]                 P0_IN_ENABLE_O,
    input wire logic                       SERIAL_TX_I,
    input wire logic                       SERIAL_TX_EN_I,
    input wire logic                       SERIAL_RX_O,
    input wire logic                       TWI_EN_I,
    input wire logic                       EXTERNAL_IRQ_ZERO_PIN_O,
    input wire logic [7:0]                 KEYPAD_IN_O,
    input wire logic                       OSC_AMP_OUT_SEL_O,
    input wire logic                       OSC_INPUT_PIN_O,
    input wire logic                       CHIP_RESET_O,
    input wire logic [31:0]                RESTART_ADDR_O
);
    timeunit 1ns;
    timeprecision 1ps;
    import port_mux_pkg::*;
    logic       rst_req;
    assign rst_req = CONFIG_I.reset_pin_en & ~P1_IN_I[PIN_RESET];
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    restart_zero_a: assert property (RESTART_ADDR_O == 32'h0)
        else $error("restart address not zero");
    chip_reset_a: assert property (!$past(RST_I) |-> CHIP_RESET_O == $past(rst_req))
        else $error("chip reset not from reset pin");
    no_drive_a: assert property (!P1_OE_O[PIN_RESET])
        else $error("reset pin driven");
    twi_open_a: assert property (TWI_EN_I |-> (P1_OE_O[3:2] & P1_OUT_O[3:2]) == 2'b00)
        else $error("two-wire pin driven high");
    osc_sel_a: assert property (OSC_AMP_OUT_SEL_O == CONFIG_I.crystal_en)
        else $error("oscillator select wrong");
    osc_in_a: assert property (OSC_INPUT_PIN_O == (CONFIG_I.crystal_en & P2_IN_I[1]))
        else $error("oscillator input wrong");
    tx_route_a: assert property (SERIAL_TX_EN_I && P1_OE_O[0] |-> P1_OUT_O[0] == SERIAL_TX_I)
        else $error("transmit not on pin");
    rx_route_a: assert property (!$past(RST_I) |-> SERIAL_RX_O == $past(P1_IN_I[1]))
        else $error("receive not from pin");
    irq_route_a: assert property (!$past(RST_I) |-> EXTERNAL_IRQ_ZERO_PIN_O == $past(P1_IN_I[3]))
        else $error("irq zero not from pin");
    keypad_mask_a: assert property (!$past(RST_I) |->
        KEYPAD_IN_O == ($past(P0_IN_I) & P0_IN_ENABLE_O))
        else $error("keypad inputs wrong");
    rst_seen_c: cover property (CHIP_RESET_O);
    twi_low_c: cover property (TWI_EN_I && P1_OE_O[2]);
    tx_low_c: cover property (SERIAL_TX_EN_I && !P1_IN_I[0]);
endmodule
bind port_pin_function_mux port_pin_function_mux_asserts port_pin_function_mux_asserts_i (
    .CLK_I, .RST_I, .CONFIG_I, .P0_IN_I, .P1_IN_I, .P2_IN_I, .P1_OUT_O, .P1_OE_O,
    .P0_IN_ENABLE_O, .SERIAL_TX_I, .SERIAL_TX_EN_I, .SERIAL_RX_O, .TWI_EN_I,
    .EXTERNAL_IRQ_ZERO_PIN_O, .KEYPAD_IN_O, .OSC_AMP_OUT_SEL_O, .OSC_INPUT_PIN_O,
    .CHIP_RESET_O, .RESTART_ADDR_O);
`default_nettype wire

// File: tb/test_port_pin_function_mux.sv
// Testbench for port_pin_function_mux: APB register traffic and pin routing.
// Assumes the board model pulls released pins high; reads are checked from a note queue.
`default_nettype none
module test_port_pin_function_mux;
    timeunit 1ns;
    timeprecision 1ps;
    import port_mux_pkg::*;
    logic         CLK_I = 0, RST_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
    logic  [11:0] PADDR_I = '0;
    logic  [31:0] PWDATA_I = '0, PRDATA_O, RESTART_ADDR_O;
    logic         SERIAL_TX_I = 1, SERIAL_TX_EN_I = 0, TWI_EN_I = 0, TWI_SCL_I = 1;
    logic         TWI_SDA_I = 1, TIMER_ZERO_OVF_I = 0, TIMER_ONE_OVF_I = 0;
    logic         PREADY_O, PSLVERR_O, SERIAL_RX_O, TWI_SCL_O, TWI_SDA_O, CHIP_RESET_O;
    logic         TIMER_ZERO_PIN_O, TIMER_ONE_PIN_O, OSC_AMP_OUT_SEL_O, OSC_INPUT_PIN_O;
    logic         EXTERNAL_IRQ_ZERO_PIN_O, EXTERNAL_IRQ_ONE_PIN_O;
    logic  [7:0]  P0_IN_I, P0_OUT_O, P0_OE_O, P1_IN_I, P1_OUT_O, P1_OE_O;
    logic  [7:0]  SCHMITT_EN_O, P0_IN_ENABLE_O, KEYPAD_IN_O, v;
    logic  [1:0]  P2_IN_I, P2_OUT_O, P2_OE_O;
    user_config_s CONFIG_I = 3'b101;
    logic  [17:0] pin, ext_en = '0, ext = '0;
    logic  [8:0]  q[$];
    logic  [8:0]  note;
    logic  [31:0] seed = 32'h9ece;
    logic  [7:0]  regs[7] = '{IDX_P0_MODE_A, IDX_P0_MODE_B, IDX_P1_MODE_A, IDX_P1_MODE_B,
                              IDX_P2_MODE_A, IDX_P2_MODE_B, IDX_P0_IN_DIS};
    int           fails = 0, n_tests = 0, cyc = 0, rises;

    port_pin_function_mux port_pin_function_mux_i (
        .CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O,
        .PREADY_O, .PSLVERR_O, .CONFIG_I, .P0_IN_I, .P0_OUT_O, .P0_OE_O, .P1_IN_I,
        .P1_OUT_O, .P1_OE_O, .P2_IN_I, .P2_OUT_O, .P2_OE_O, .SCHMITT_EN_O, .P0_IN_ENABLE_O,
        .SERIAL_TX_I, .SERIAL_TX_EN_I, .SERIAL_RX_O, .TWI_EN_I, .TWI_SCL_I, .TWI_SDA_I,
        .TWI_SCL_O, .TWI_SDA_O, .TIMER_ZERO_OVF_I, .TIMER_ONE_OVF_I, .TIMER_ZERO_PIN_O,
        .TIMER_ONE_PIN_O, .EXTERNAL_IRQ_ZERO_PIN_O, .EXTERNAL_IRQ_ONE_PIN_O, .KEYPAD_IN_O,
        .OSC_AMP_OUT_SEL_O, .OSC_INPUT_PIN_O, .CHIP_RESET_O, .RESTART_ADDR_O);
    port_board_model port_board_model_i (
        .out_i({P2_OUT_O, P1_OUT_O, P0_OUT_O}), .oe_i({P2_OE_O, P1_OE_O, P0_OE_O}),
        .ext_en_i(ext_en), .ext_i(ext), .pin_o(pin));
    assign {P2_IN_I, P1_IN_I, P0_IN_I} = pin;

    always #12.5 CLK_I = ~CLK_I;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask

    task finish_test;
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Request held until pready is seen; read expectation noted at setup
    task automatic apb(input logic w, input logic [7:0] idx, d, input logic [8:0] e);
        PSEL_I <= 1;
        PWRITE_I <= w;
        PADDR_I <= {2'b00, idx, 2'b00};
        PWDATA_I <= {24'h0, d};
        if (!w) q.push_back(e);
        @(posedge CLK_I);
        PENABLE_I <= 1;
        @(posedge CLK_I);
        while (PREADY_O !== 1'b1) begin
            @(posedge CLK_I);
        end
        PSEL_I <= 0;
        PENABLE_I <= 0;
        @(posedge CLK_I);
    endtask

    always @(posedge CLK_I) begin
        if (PSEL_I && PENABLE_I && PREADY_O === 1'b1 && !PWRITE_I && q.size() > 0) begin
            note = q.pop_front();
            chk({PSLVERR_O, PRDATA_O}, {note[8], 24'h0, note[7:0]});
        end
    end

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        repeat (10) @(posedge CLK_I);
        RST_I <= 0;
        repeat (2) @(posedge CLK_I);
        apb(0, IDX_P0_LATCH, 8'h0, 9'h0ff);
        apb(0, IDX_P1_LATCH, 8'h0, 9'h0ff);
        apb(0, IDX_P2_LATCH, 8'h0, 9'h003);
        for (int i = 0; i < 7; i++) apb(0, regs[i], 8'h0, 9'h000);
        apb(0, 8'h00, 8'h0, 9'h100);
        apb(1, IDX_P1_MODE_A, 8'hff, 9'h0);
        apb(0, IDX_P1_MODE_A, 8'h0, {1'b0, P1_MODE_WMASK});
        apb(1, IDX_P1_MODE_A, 8'h00, 9'h0);
        apb(1, IDX_P2_MODE_B, 8'hff, 9'h0);
        apb(0, IDX_P2_MODE_B, 8'h0, {1'b0, P2_MODE_B_WMASK});
        apb(1, IDX_P2_MODE_B, 8'h00, 9'h0);
        // Pins 3..0: open-drain, input-only, push-pull, quasi
        apb(1, IDX_P0_MODE_A, 8'h0c, 9'h0);
        apb(1, IDX_P0_MODE_B, 8'h0a, 9'h0);
        apb(1, IDX_P0_LATCH, 8'h00, 9'h0);
        #5 chk(33'({P0_OE_O[3:0], P0_OUT_O[3:0] & P0_OE_O[3:0]}), 33'hb0);
        @(posedge CLK_I);
        apb(1, IDX_P0_LATCH, 8'hff, 9'h0);
        repeat (3) @(posedge CLK_I);
        #5 chk(33'({P0_OE_O[3:0], P0_OUT_O[1]}), 33'h05);
        @(posedge CLK_I);
        apb(1, IDX_P0_MODE_A, 8'h00, 9'h0);
        apb(1, IDX_P0_MODE_B, 8'hff, 9'h0);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            v = seed[7:0];
            apb(1, IDX_P0_LATCH, v, 9'h0);
            apb(0, IDX_P0_LATCH, 8'h0, {1'b0, v});
            #5 chk(33'({P0_OE_O, P0_OUT_O}), 33'({8'hff, v}));
            @(posedge CLK_I);
        end
        apb(1, IDX_P0_MODE_B, 8'h00, 9'h0);
        apb(1, IDX_P0_MODE_A, 8'h30, 9'h0);
        apb(1, IDX_P0_LATCH, 8'hff, 9'h0);
        apb(1, IDX_P0_IN_DIS, 8'h30, 9'h0);
        apb(0, IDX_P0_LATCH, 8'h0, 9'h0cf);
        #5 chk(33'(P0_IN_ENABLE_O), 33'hcf);
        @(posedge CLK_I);
        apb(1, IDX_P2_MODE_A, 8'ha0, 9'h0);
        apb(0, IDX_P2_MODE_A, 8'h0, 9'h0a0);
        #5 chk(33'(SCHMITT_EN_O[2:0]), 33'h5);
        @(posedge CLK_I);
        apb(1, IDX_P2_MODE_A, 8'h10, 9'h0);
        repeat (6) @(posedge CLK_I);
        #1 v[0] = pin[16];
        rises = 0;
        for (int i = 0; i < 60; i++) begin
            @(posedge CLK_I);
            #1 rises += int'(pin[16] && !v[0]);
            v[0] = pin[16];
        end
        chk(33'(rises), 33'd10);
        @(posedge CLK_I);
        apb(1, IDX_P2_MODE_A, 8'h04, 9'h0);
        #5 v[1] = pin[10];
        @(posedge CLK_I);
        TIMER_ZERO_OVF_I <= 1;
        @(posedge CLK_I);
        TIMER_ZERO_OVF_I <= 0;
        repeat (2) @(posedge CLK_I);
        #5 chk(33'({v[1], pin[10], TIMER_ZERO_PIN_O, EXTERNAL_IRQ_ONE_PIN_O}), 33'h7);
        @(posedge CLK_I);
        SERIAL_TX_EN_I <= 1;
        SERIAL_TX_I <= 0;
        TWI_EN_I <= 1;
        TWI_SCL_I <= 0;
        ext_en[13] <= 1;
        ext[13] <= 0;
        repeat (3) @(posedge CLK_I);
        #5 chk(33'({pin[8], pin[10], pin[11], P1_OE_O[3], CHIP_RESET_O}), 33'h05);
        @(posedge CLK_I);
        SERIAL_TX_I <= 1;
        ext_en[13] <= 0;
        CONFIG_I.crystal_en <= 1;
        repeat (3) @(posedge CLK_I);
        #5 chk(33'({pin[8], CHIP_RESET_O}), 33'h2);
        finish_test();
    end
endmodule
`default_nettype wire
